// ==== common/csm_pkg.sv ====
// constants for the codec serial mode control block
package csm_pkg;
    localparam int WORD_W = 16;
    localparam int DATA_W = 8;
    localparam int RA_W = 3;
    // control word fields
    localparam int CW_FLAG = 15;
    localparam int CW_RW = 14;
    localparam int CW_DEV_HI = 13;
    localparam int CW_DEV_LO = 11;
    localparam int CW_REG_HI = 10;
    localparam int CW_REG_LO = 8;
    // register addresses
    localparam logic [2:0] REG_A = 3'h0;
    localparam logic [2:0] REG_B = 3'h1;
    localparam logic [2:0] REG_C = 3'h2;
    localparam logic [2:0] REG_D = 3'h3;
    localparam logic [2:0] REG_E = 3'h4;
    localparam int NUM_REGS = 5;
    // control_reg_a fields
    localparam int A_RUN = 0;
    localparam int A_MIX = 1;
    localparam int A_ALB = 2;
    localparam int A_DLB = 3;
    localparam int A_DC_LO = 4;
    localparam int A_DC_HI = 6;
    // converter timing register: bits 7:6 always zero
    localparam logic [7:0] E_MASK = 8'h3F;
    localparam logic [7:0] REG_RST = 8'h00;
    // frame pacing in divided master clock periods
    localparam int SLOW_PERIOD = 2048;
    localparam int FAST_PERIOD = 256;
    localparam int FCNT_W = 11;
    localparam logic [4:0] BITS_PER_WORD = 5'h10;
    localparam logic [4:0] CNT_ONE = 5'h01;
    localparam logic [4:0] CNT_ZERO = 5'h00;
endpackage : csm_pkg

// ==== hdl/csm_serial_ctl.sv ====
// serial port front end: mode decode, cascade addressing and control registers
module csm_serial_ctl
    import csm_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // divided master clock enable pulse
    input wire logic divided_master_clock_en,
    // serial port pins
    input wire logic port_enable_pin,
    input wire logic serial_in,
    input wire logic in_frame_sync,
    output logic serial_clk,
    output logic serial_out,
    output logic out_frame_sync,
    // converter side
    input wire logic [WORD_W-1:0] adc_sample,
    output logic [WORD_W-1:0] dac_word,
    output logic dac_load,
    // register outputs
    output logic [7:0] control_reg_a,
    output logic [2:0] input_gain_sel,
    output logic modulator_reset,
    output logic [2:0] output_gain_sel,
    output logic output_mute,
    output logic [4:0] conversion_lead,
    output logic interp_bypass
);
    logic [7:0] regs [NUM_REGS];
    logic rate_fast;
    logic [FCNT_W-1:0] frame_cnt;
    logic bit_en;
    logic tick;
    logic [4:0] rx_cnt;
    logic [WORD_W-1:0] rx_sh;
    logic [WORD_W-1:0] rx_word;
    logic rx_done;
    logic [2:0] fs_cnt;
    logic own_frame;
    logic [4:0] tx_cnt;
    logic [WORD_W-1:0] tx_sh;
    logic [WORD_W-2:0] dly_dat;
    logic [WORD_W-2:0] dly_fs;
    logic pend_valid;
    logic [WORD_W-1:0] pend_word;
    logic run_select;
    logic interleave_enable;
    logic analog_loopback;
    logic digital_loopback;
    logic [2:0] cascade_count;
    logic is_ctrl;
    logic [2:0] dev_addr;
    logic [2:0] reg_addr;
    logic [7:0] next_a;
    logic [WORD_W-1:0] next_tx;

    typedef enum logic [1:0] {CSM_PROGRAM, CSM_DATA, CSM_MIXED} csm_mode_t;
    csm_mode_t mode;

    function automatic logic [FCNT_W-1:0] period_last(input logic fast);
        period_last = fast ? FCNT_W'(FAST_PERIOD - 1) : FCNT_W'(SLOW_PERIOD - 1);
    endfunction

    assign run_select = control_reg_a[A_RUN];
    assign interleave_enable = control_reg_a[A_MIX];
    assign analog_loopback = control_reg_a[A_ALB];
    assign digital_loopback = control_reg_a[A_DLB];
    assign cascade_count = control_reg_a[A_DC_HI:A_DC_LO];
    assign control_reg_a = regs[REG_A];
    assign input_gain_sel = regs[REG_D][2:0];
    assign modulator_reset = regs[REG_D][3];
    assign output_gain_sel = regs[REG_D][6:4];
    assign output_mute = regs[REG_D][7];
    assign conversion_lead = regs[REG_E][4:0];
    assign interp_bypass = regs[REG_E][5];

    always_comb begin
        if (!run_select) begin
            mode = CSM_PROGRAM;
        end else if (interleave_enable) begin
            mode = CSM_MIXED;
        end else begin
            mode = CSM_DATA;
        end
    end

    // bit clock follows the divided master clock while the port is enabled
    assign bit_en = divided_master_clock_en && port_enable_pin;
    assign tick = bit_en && (frame_cnt == '0);

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            serial_clk <= 1'b0;
        end else begin
            serial_clk <= bit_en;
        end
    end

    // output frame pacing
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            frame_cnt <= '0;
        end else if (bit_en) begin
            if (frame_cnt == '0) begin
                frame_cnt <= period_last(rate_fast);
            end else begin
                frame_cnt <= frame_cnt - 1'b1;
            end
        end
    end

    // input deserialiser; a sync during the last bit restarts cleanly
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rx_cnt <= CNT_ZERO;
            rx_sh <= '0;
            rx_word <= '0;
            rx_done <= 1'b0;
        end else begin
            rx_done <= 1'b0;
            if (bit_en) begin
                if (rx_cnt != CNT_ZERO) begin
                    rx_sh <= {rx_sh[WORD_W-2:0], serial_in};
                end
                if (rx_cnt == CNT_ONE) begin
                    rx_word <= {rx_sh[WORD_W-2:0], serial_in};
                    rx_done <= 1'b1;
                end
                if (in_frame_sync) begin
                    rx_cnt <= BITS_PER_WORD;
                end else if (rx_cnt != CNT_ZERO) begin
                    rx_cnt <= rx_cnt - 1'b1;
                end
            end
        end
    end

    // input sync counting selects this device's slot in a cascade
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            fs_cnt <= '0;
            own_frame <= 1'b0;
        end else if (bit_en && in_frame_sync && run_select) begin
            own_frame <= (fs_cnt == cascade_count);
            fs_cnt <= (fs_cnt == cascade_count) ? 3'h0 : fs_cnt + 1'b1;
        end
    end

    // word decode
    assign is_ctrl = (mode == CSM_PROGRAM) ||
        ((mode == CSM_MIXED) && rx_word[CW_FLAG]);
    assign dev_addr = rx_word[CW_DEV_HI:CW_DEV_LO];
    assign reg_addr = rx_word[CW_REG_HI:CW_REG_LO];

    // loopback bits stick unless mixed mode is on now or in the new value
    always_comb begin
        next_a = rx_word[7:0];
        if (!(interleave_enable || rx_word[A_MIX])) begin
            next_a[A_ALB] = rx_word[A_ALB] | analog_loopback;
            next_a[A_DLB] = rx_word[A_DLB] | digital_loopback;
        end
    end

    // register file; data mode never reaches here since is_ctrl is low
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < NUM_REGS; i++) begin
                regs[i] <= REG_RST;
            end
            rate_fast <= 1'b0;
        end else if (rx_done && is_ctrl && dev_addr == 3'h0 && !rx_word[CW_RW]) begin
            case (reg_addr)
                REG_A: regs[REG_A] <= next_a;
                REG_B: begin
                    regs[REG_B] <= rx_word[7:0];
                    rate_fast <= 1'b1;
                end
                REG_C: regs[REG_C] <= rx_word[7:0];
                REG_D: regs[REG_D] <= rx_word[7:0];
                REG_E: regs[REG_E] <= rx_word[7:0] & E_MASK;
                default: ;
            endcase
        end
    end

    // words queued for the next output slot: passed on or read back
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            pend_valid <= 1'b0;
            pend_word <= '0;
        end else begin
            if (tick) begin
                pend_valid <= 1'b0;
            end
            // a new word beats the slot that drains the old one
            if (rx_done && is_ctrl) begin
                if (dev_addr != 3'h0) begin
                    pend_valid <= 1'b1;
                    pend_word <= rx_word;
                    pend_word[CW_DEV_HI:CW_DEV_LO] <= dev_addr - 1'b1;
                end else if (rx_word[CW_RW]) begin
                    pend_valid <= 1'b1;
                    pend_word <= {rx_word[WORD_W-1:DATA_W],
                        (reg_addr < 3'(NUM_REGS)) ? regs[reg_addr] : 8'h00};
                end
            end
        end
    end

    // converter register
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            dac_word <= '0;
            dac_load <= 1'b0;
        end else begin
            dac_load <= 1'b0;
            if (analog_loopback) begin
                if (tick) begin
                    dac_word <= adc_sample;
                    dac_load <= 1'b1;
                end
            end else if (rx_done && own_frame && mode == CSM_DATA) begin
                dac_word <= rx_word;
                dac_load <= 1'b1;
            end else if (rx_done && own_frame && mode == CSM_MIXED && !rx_word[CW_FLAG]) begin
                dac_word <= {rx_word[WORD_W-2:0], 1'b0};
                dac_load <= 1'b1;
            end
        end
    end

    always_comb begin
        if (pend_valid) begin
            next_tx = pend_word;
        end else if (mode == CSM_MIXED) begin
            next_tx = {1'b0, adc_sample[WORD_W-2:0]};
        end else begin
            next_tx = adc_sample;
        end
    end

    // serialiser and digital loopback delay line
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            tx_cnt <= CNT_ZERO;
            tx_sh <= '0;
            dly_dat <= '0;
            dly_fs <= '0;
            serial_out <= 1'b0;
            out_frame_sync <= 1'b0;
        end else if (bit_en) begin
            // one stage short of a word: the output flop is the sixteenth bit of delay
            dly_dat <= {dly_dat[WORD_W-3:0], serial_in};
            dly_fs <= {dly_fs[WORD_W-3:0], in_frame_sync};
            if (tick) begin
                tx_sh <= next_tx;
                tx_cnt <= BITS_PER_WORD;
            end else if (tx_cnt != CNT_ZERO) begin
                tx_sh <= {tx_sh[WORD_W-2:0], 1'b0};
                tx_cnt <= tx_cnt - 1'b1;
            end
            if (digital_loopback) begin
                serial_out <= dly_dat[WORD_W-2];
                out_frame_sync <= dly_fs[WORD_W-2];
            end else begin
                serial_out <= (tx_cnt != CNT_ZERO) ? tx_sh[WORD_W-1] : 1'b0;
                out_frame_sync <= tick;
            end
        end
    end

    // checks
    property p_prog_ctrl;
        @(posedge sys_clk) disable iff (!rst_b)
        (rx_done && mode == CSM_PROGRAM && dev_addr == 3'h0 && !rx_word[CW_RW]
            && reg_addr == REG_D) |=> regs[REG_D] == DATA_W'($past(rx_word));
    endproperty
    a_prog_ctrl: assert property (p_prog_ctrl) else $error("program frame not control");

    property p_pass_dec;
        @(posedge sys_clk) disable iff (!rst_b)
        (rx_done && is_ctrl && dev_addr != 3'h0) |=>
            pend_valid && pend_word[CW_DEV_HI:CW_DEV_LO] == $past(dev_addr) - 3'h1;
    endproperty
    a_pass_dec: assert property (p_pass_dec) else $error("address not decremented");

    property p_fs_one_bit;
        @(posedge sys_clk) disable iff (!rst_b)
        (bit_en && !digital_loopback) |=> out_frame_sync == $past(tick);
    endproperty
    a_fs_one_bit: assert property (p_fs_one_bit) else $error("frame sync wrong");

    property p_slow_rate;
        @(posedge sys_clk) disable iff (!rst_b)
        (tick && !rate_fast) |=> frame_cnt == FCNT_W'(SLOW_PERIOD - 1);
    endproperty
    a_slow_rate: assert property (p_slow_rate) else $error("slow period wrong");

    property p_data_load;
        @(posedge sys_clk) disable iff (!rst_b)
        (rx_done && own_frame && mode == CSM_DATA && !analog_loopback) |=>
            dac_load && dac_word == $past(rx_word);
    endproperty
    a_data_load: assert property (p_data_load) else $error("data word not loaded");

    property p_lock;
        @(posedge sys_clk) disable iff (!rst_b)
        (mode == CSM_DATA) |=> $stable(control_reg_a) && $stable(regs[REG_D]);
    endproperty
    a_lock: assert property (p_lock) else $error("register changed in data mode");

    property p_mixed_load;
        @(posedge sys_clk) disable iff (!rst_b)
        (rx_done && own_frame && mode == CSM_MIXED && !rx_word[CW_FLAG] && !analog_loopback)
            |=> dac_word[0] == 1'b0 && dac_load;
    endproperty
    a_mixed_load: assert property (p_mixed_load) else $error("mixed data not justified");

    property p_alb_hold;
        @(posedge sys_clk) disable iff (!rst_b)
        (analog_loopback && !interleave_enable) |=> analog_loopback;
    endproperty
    a_alb_hold: assert property (p_alb_hold) else $error("loopback cleared");

    property p_reg_e;
        @(posedge sys_clk) disable iff (!rst_b)
        regs[REG_E][7:6] == 2'h0;
    endproperty
    a_reg_e: assert property (p_reg_e) else $error("reserved bits set");

    c_fast: cover property (@(posedge sys_clk) disable iff (!rst_b) $rose(rate_fast));
    c_data: cover property (@(posedge sys_clk) disable iff (!rst_b) dac_load && mode == CSM_DATA);
    c_mixed: cover property (@(posedge sys_clk) disable iff (!rst_b)
        rx_done && is_ctrl && mode == CSM_MIXED);
    c_pass: cover property (@(posedge sys_clk) disable iff (!rst_b)
        tick && pend_valid);
endmodule // csm_serial_ctl

// ==== bench/csm_dsp_model.sv ====
// behavioural dsp serial port facing the codec serial port
module csm_dsp_model
    import csm_pkg::*;
(
    // clock and bit timing
    input wire logic sys_clk,
    input wire logic bit_tick,
    // codec pins
    input wire logic serial_out,
    input wire logic out_frame_sync,
    output logic serial_in,
    output logic in_frame_sync,
    // last word taken from the codec
    output logic [WORD_W-1:0] rx_word,
    output logic rx_done
);
    timeunit 1ns;
    timeprecision 1ps;
    int rx_left = 0;
    logic [WORD_W-1:0] rx_sh = '0;

    initial begin
        serial_in = 1'b0;
        in_frame_sync = 1'b0;
        rx_word = '0;
        rx_done = 1'b0;
    end

    // sync for one bit ahead of the word, then msb first
    task automatic send(input logic [WORD_W-1:0] w);
        @(posedge sys_clk iff bit_tick);
        in_frame_sync <= 1'b1;
        for (int i = WORD_W - 1; i >= 0; i--) begin
            @(posedge sys_clk iff bit_tick);
            in_frame_sync <= 1'b0;
            serial_in <= w[i];
        end
        @(posedge sys_clk iff bit_tick);
        // released line: inverse of the last bit so stale data cannot pass
        serial_in <= ~w[0];
    endtask

    // receive frames framed by the codec's own sync
    always @(posedge sys_clk) begin
        rx_done <= 1'b0;
        if (bit_tick && rx_left > 0) begin
            rx_sh = {rx_sh[WORD_W-2:0], serial_out};
            rx_left <= rx_left - 1;
            if (rx_left == 1) begin
                rx_word <= rx_sh;
                rx_done <= 1'b1;
            end
        end else if (bit_tick && out_frame_sync) begin
            rx_left <= WORD_W;
        end
    end
endmodule // csm_dsp_model

// ==== bench/csm_serial_ctl_tb_top.sv ====
// self-checking bench for the codec serial mode control block
module csm_serial_ctl_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import csm_pkg::*;
    logic sys_clk, rst_b, divided_master_clock_en, port_enable_pin, serial_in, in_frame_sync;
    logic serial_clk, serial_out, out_frame_sync, dac_load, modulator_reset, output_mute;
    logic interp_bypass, ofs_q, rx_done;
    logic [2:0] input_gain_sel, output_gain_sel;
    logic [4:0] conversion_lead;
    logic [7:0] control_reg_a;
    logic [WORD_W-1:0] adc_sample, dac_word, rx_word;
    int bad_count = 0;
    int samples_checked = 0;
    int loads = 0;
    // bit cycles since the last input sync, 1 at the sync itself
    int ifs_age = 0;
    int echo_lag = 0;
    wire logic bit_tick = divided_master_clock_en && port_enable_pin;
    wire logic [15:0] gm = {8'h00, output_mute, output_gain_sel, modulator_reset, input_gain_sel};
    wire logic [15:0] te = {10'h000, interp_bypass, conversion_lead};

    csm_serial_ctl dut (.sys_clk(sys_clk), .rst_b(rst_b), .divided_master_clock_en(divided_master_clock_en),
        .port_enable_pin(port_enable_pin), .serial_in(serial_in),
        .in_frame_sync(in_frame_sync), .serial_clk(serial_clk), .serial_out(serial_out),
        .out_frame_sync(out_frame_sync), .adc_sample(adc_sample), .dac_word(dac_word),
        .dac_load(dac_load), .control_reg_a(control_reg_a), .input_gain_sel(input_gain_sel),
        .modulator_reset(modulator_reset), .output_gain_sel(output_gain_sel),
        .output_mute(output_mute), .conversion_lead(conversion_lead),
        .interp_bypass(interp_bypass));
    csm_dsp_model dsp (.sys_clk(sys_clk), .bit_tick(bit_tick), .serial_out(serial_out),
        .out_frame_sync(out_frame_sync), .serial_in(serial_in),
        .in_frame_sync(in_frame_sync), .rx_word(rx_word), .rx_done(rx_done));

    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    // bit cycle on every other clock
    always @(posedge sys_clk) begin
        divided_master_clock_en <= ~divided_master_clock_en;
        ofs_q <= out_frame_sync;
        if (dac_load === 1'b1) begin
            loads++;
        end
        if (bit_tick) begin
            ifs_age <= in_frame_sync ? 1 : ifs_age + 1;
        end
        if (out_frame_sync === 1'b1 && ofs_q === 1'b0) begin
            echo_lag <= ifs_age;
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // 0: sync rise, 1: word received, 2: converter load
    task automatic wait_for(input int which);
        for (int n = 0; n < 5000; n++) begin
            @(posedge sys_clk);
            if ((which == 0 && out_frame_sync === 1'b1 && ofs_q === 1'b0) ||
                (which == 1 && rx_done === 1'b1) || (which == 2 && dac_load === 1'b1)) begin
                return;
            end
        end
        bad_count++;
        $display("[FAIL] %0t wait ran out", $time);
        conclude();
    endtask

    task automatic measure(input int exp);
        int n;
        wait_for(0);
        for (n = 1; n < 5000; n++) begin
            @(posedge sys_clk);
            if (out_frame_sync === 1'b1 && ofs_q === 1'b0) begin
                break;
            end
        end
        check(16'(n), 16'(exp));
    endtask

    task automatic do_reset();
        rst_b <= 1'b0;
        repeat (12) @(posedge sys_clk);
        rst_b <= 1'b1;
    endtask

    // control word sent one bit after the codec's output word starts
    task automatic wr(input logic [2:0] dev, input logic rw, input logic [2:0] ra,
        input logic [7:0] d);
        wait_for(0);
        dsp.send({1'b1, rw, dev, ra, d});
        repeat (4) @(posedge sys_clk);
    endtask

    task automatic t_enable_rate();
        int n;
        do_reset();
        repeat (40) @(posedge sys_clk);
        check(16'(out_frame_sync), 16'h0000);
        check({control_reg_a, gm[7:0]}, 16'h0000);
        check(te, 16'h0000);
        port_enable_pin <= 1'b1;
        measure(2 * SLOW_PERIOD);
        n = 0;
        repeat (20) begin
            @(posedge sys_clk);
            n += int'(serial_clk);
        end
        check(16'(n), 16'h000A);
        wr(3'h0, 1'b0, REG_B, 8'h03);
        measure(2 * FAST_PERIOD);
    endtask

    task automatic t_prog();
        wr(3'h0, 1'b0, REG_D, 8'hA5);
        check(gm, 16'h00A5);
        wr(3'h0, 1'b0, REG_E, 8'hFF);
        check(te, 16'h003F);
        wr(3'h2, 1'b0, REG_D, 8'h00);
        wait_for(1);
        check(rx_word, {1'b1, 1'b0, 3'h1, REG_D, 8'h00});
        check(gm, 16'h00A5);
        wr(3'h0, 1'b1, REG_D, 8'h00);
        wait_for(1);
        check(rx_word, 16'hC3A5);
    endtask

    task automatic t_mixed();
        do_reset();
        // first word rides the first output frame after reset
        wr(3'h0, 1'b0, REG_A, 8'h03);
        check(16'(control_reg_a), 16'h0003);
        wait_for(0);
        dsp.send(16'h1234);
        wait_for(2);
        check(dac_word, 16'h2468);
        wait_for(1);
        check(rx_word, 16'h7FFF);
        wr(3'h0, 1'b0, REG_D, 8'h5A);
        check(gm, 16'h005A);
        adc_sample <= 16'h5555;
        wr(3'h0, 1'b0, REG_A, 8'h07);
        wait_for(2);
        check(dac_word, 16'h5555);
        wr(3'h0, 1'b0, REG_A, 8'h03);
        check(16'(control_reg_a), 16'h0003);
    endtask

    task automatic t_data();
        do_reset();
        wr(3'h0, 1'b0, REG_A, 8'h01);
        dsp.send(16'h8B0F);
        wait_for(2);
        check(dac_word, 16'h8B0F);
        // a control-shaped word must land as converter data, not as a write
        dsp.send({1'b1, 1'b0, 3'h0, REG_D, 8'hFF});
        wait_for(2);
        check(dac_word, 16'h83FF);
        check(gm, 16'h0000);
    endtask

    task automatic t_cascade();
        do_reset();
        wr(3'h0, 1'b0, REG_A, 8'h11);
        loads = 0;
        dsp.send(16'h1357);
        dsp.send(16'h2468);
        repeat (20) @(posedge sys_clk);
        check(16'(loads), 16'h0001);
        check(dac_word, 16'h2468);
    endtask

    task automatic t_dlb();
        do_reset();
        wr(3'h0, 1'b0, REG_A, 8'h0C);
        // let the echo of the enabling word drain first
        repeat (80) @(posedge sys_clk);
        dsp.send(16'hC3A5);
        wait_for(1);
        check(rx_word, 16'hC3A5);
        check(16'(echo_lag), 16'(WORD_W));
        dsp.send({1'b1, 1'b0, 3'h0, REG_A, 8'h00});
        repeat (8) @(posedge sys_clk);
        check(16'(control_reg_a), 16'h000C);
    endtask

    initial begin
        rst_b = 1'b0;
        divided_master_clock_en = 1'b0;
        port_enable_pin = 1'b0;
        adc_sample = 16'hFFFF;
        t_enable_rate();
        t_prog();
        t_mixed();
        t_data();
        t_cascade();
        t_dlb();
        conclude();
    end
endmodule // csm_serial_ctl_tb_top
